// ---- rtl/itu_trace_unit.sv ----
// Per-thread program-flow trace units, their FIFOs and the output funnel
// Overview of operation
// - Eight resource pairs, two full counters only
// - Thirty-two inputs via four external selectors
// - Sequencer has exactly four states
// - Four address pairs, single-shot, machine and context IDs
// - Core branches and exceptions kept in order
// - Build compressed packets from flow elements
// - Address-range and resource filtering gates trace
// - Trigger tells capture sink to stop
// - Full FIFO flags overflow, trace waits drain
// - Drained FIFO data leaves on ATB master
// - Funnel merges thread streams onto one ATB
// - Only cold reset clears unit state
// - After reset, no trace until re-enabled
// - All thread units share one reset
// - Registers reached only through programming port
// - Programming accepted while core runs normally
// - Agent commits all configuration at once
// - Clearing enable bit turns tracing off
// - Thread reaches only its own unit
// - Four selectors each pick one monitor event
// - Any event selector but single-shot, which picks an address pair, may use selector outputs
// - Attributable events only to owning thread
`timescale 1ns/1ps
`include "itu_cfg.svh"

module itu_fifo #(
    parameter int W     = `ITU_DATA_W,
    parameter int DEPTH = `ITU_FIFO_DEPTH
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [W-1:0]  mem_r [DEPTH];
    logic [AW-1:0] wp_r;
    logic [AW-1:0] rp_r;
    logic [AW:0]   cnt_r;
    wire           push = in_valid & in_ready;
    wire           pop  = out_valid & out_ready;
    assign in_ready  = (cnt_r != (AW+1)'(DEPTH));
    assign out_valid = (cnt_r != '0);
    assign out_data  = mem_r[rp_r];
    always_ff @(posedge clk) begin
        if (push) mem_r[wp_r] <= in_data;
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wp_r  <= '0;
            rp_r  <= '0;
            cnt_r <= '0;
        end else begin
            if (push) wp_r <= (wp_r == AW'(DEPTH-1)) ? '0 : wp_r + 1'b1;
            if (pop)  rp_r <= (rp_r == AW'(DEPTH-1)) ? '0 : rp_r + 1'b1;
            cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

module itu_thread_unit import itu_pkg::*; (
    input  wire logic                         clk,
    input  wire logic                         rst,
    input  wire logic                         cfg_we,
    input  wire logic [`ITU_IDX_W-1:0]        cfg_idx,
    input  wire logic [31:0]                  cfg_wdata,
    input  wire logic                         elem_valid,
    input  wire logic [1:0]                   elem_kind,
    input  wire logic [`ITU_ADDR_W-1:0]       elem_addr,
    input  wire logic [31:0]                  ctx_id,
    input  wire logic [31:0]                  vm_ident,
    input  wire logic [`ITU_NUM_XTRIG-1:0]    xtrig,
    input  wire logic [`ITU_NUM_PERF-1:0]     perf_evt,
    output logic                              out_valid,
    input  wire logic                         out_ready,
    output logic [`ITU_DATA_W-1:0]            out_data,
    output logic                              trig,
    output logic [31:0]                       status
);
    logic [31:0]            sh_r  [`ITU_CFG_WORDS];
    logic [31:0]            act_r [`ITU_CFG_WORDS];
    logic                   en_r, ovf_r, ovf_seen_r, trig_done_r, sshot_r, ev_r;
    logic [1:0]             kind_r;
    logic [`ITU_ADDR_W-1:0] addr_r, last_r;
    logic [15:0]            cnt_r [`ITU_NUM_CNT];
    itu_seq_t               seq_r, seq_nxt;
    wire [`ITU_RES_N-1:0]   res;
    wire [`ITU_NUM_RSP-1:0] pair;
    wire [31:0]             ext_in = {perf_evt, xtrig};
    wire                    ctrl_wr = cfg_we & (cfg_idx == `ITU_IDX_CTRL);
    wire                    fifo_rdy, fifo_empty;

    // Staging words are copied in one step on the control write, so no
    // counter or comparator ever acts on a half-written setup
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < `ITU_CFG_WORDS; i++) begin
                sh_r[i]  <= '0;
                act_r[i] <= '0;
            end
            en_r <= 1'b0;
        end else if (cfg_we) begin
            sh_r[cfg_idx] <= cfg_wdata;
            if (ctrl_wr) begin
                act_r <= sh_r;
                en_r  <= cfg_wdata[`ITU_CTRL_EN];
            end
        end
    end

    // Retired flow elements enter one per cycle and keep program order
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ev_r   <= 1'b0;
            kind_r <= 2'h0;
            addr_r <= '0;
        end else begin
            ev_r   <= elem_valid;
            kind_r <= elem_kind;
            addr_r <= elem_addr;
        end
    end

    genvar g;
    generate
        for (g = 0; g < `ITU_NUM_ACMP; g++) begin : g_acmp
            assign res[`ITU_RES_ACMP+g] = (addr_r >= act_r[`ITU_IDX_ACMP+2*g]) &&
                                          (addr_r <= act_r[`ITU_IDX_ACMP+2*g+1]);
        end
        for (g = 0; g < `ITU_NUM_EXTSEL; g++) begin : g_ext
            assign res[`ITU_RES_EXT+g] =
                ext_in[act_r[`ITU_IDX_EXTSEL][g*`ITU_EXTSEL_STEP +: `ITU_RSEL_W]];
        end
        for (g = 0; g < `ITU_NUM_CNT; g++) begin : g_cz
            assign res[`ITU_RES_CNT+g] = (cnt_r[g] == 16'h0000);
        end
        // Any pair may take selector, counter or sequencer outputs
        for (g = 0; g < `ITU_NUM_RSP; g++) begin : g_rsp
            localparam int WD = `ITU_IDX_RSEL + g / `ITU_RSP_PER_WD;
            localparam int BT = (g % `ITU_RSP_PER_WD) * 2 * `ITU_RSEL_W;
            assign pair[g] = res[act_r[WD][BT +: `ITU_RSEL_W]] |
                             res[act_r[WD][BT+`ITU_RSEL_W +: `ITU_RSEL_W]];
        end
    endgenerate
    assign res[`ITU_RES_VM]    = (vm_ident == act_r[`ITU_IDX_VM]);
    assign res[`ITU_RES_CTX]   = (ctx_id == act_r[`ITU_IDX_CTX]);
    assign res[`ITU_RES_SEQ+3:`ITU_RES_SEQ] = seq_r;
    assign res[`ITU_RES_SSHOT] = sshot_r;
    assign res[`ITU_RES_N-1:`ITU_RES_SSHOT+1] = '0;

    // Two full counters; a reduced counter is not provided
    generate
        for (g = 0; g < `ITU_NUM_CNT; g++) begin : g_cnt
            wire [31:0] cw = act_r[`ITU_IDX_CNT+g];
            always_ff @(posedge clk or posedge rst) begin
                if (rst) cnt_r[g] <= 16'h0000;
                else if (ctrl_wr) cnt_r[g] <= sh_r[`ITU_IDX_CNT+g][`ITU_CNT_RELOAD];
                else if (en_r && pair[cw[`ITU_CNT_EVT]])
                    cnt_r[g] <= (cnt_r[g] == 16'h0000) ? cw[`ITU_CNT_RELOAD]
                                                       : cnt_r[g] - 16'h0001;
            end
        end
    endgenerate

    wire [31:0] sq = act_r[`ITU_IDX_SEQ];
    always_comb begin
        seq_nxt = seq_r;
        unique case (seq_r)
            ITU_SEQ0: if (pair[sq[2:0]]) seq_nxt = ITU_SEQ1;
            ITU_SEQ1: if (pair[sq[5:3]]) seq_nxt = ITU_SEQ2;
                      else if (pair[sq[`ITU_SEQ_BACK +: 3]]) seq_nxt = ITU_SEQ0;
            ITU_SEQ2: if (pair[sq[8:6]]) seq_nxt = ITU_SEQ3;
                      else if (pair[sq[`ITU_SEQ_BACK+3 +: 3]]) seq_nxt = ITU_SEQ1;
            ITU_SEQ3: if (pair[sq[`ITU_SEQ_BACK+6 +: 3]]) seq_nxt = ITU_SEQ2;
            default:  seq_nxt = ITU_SEQ0;
        endcase
    end

    wire [31:0]                ev    = act_r[`ITU_IDX_EVT];
    wire                       view  = en_r & pair[ev[`ITU_EVT_VIEW]];
    wire                       ovf_out = ovf_r & fifo_empty;
    wire                       emit  = ev_r & view & ~ovf_r;
    wire                       push  = emit | ovf_out;
    wire                       lost  = emit & ~fifo_rdy;
    wire                       short = (kind_r == ITU_K_INDIR) & (addr_r == last_r);
    wire [`ITU_DATA_W-1:0]     pkt;
    // Direct branches and repeated indirect targets collapse to one-bit atoms
    assign pkt = ovf_out                                     ? {`ITU_HDR_OVF, 28'h0}
               : (kind_r == ITU_K_EXC)                       ? {`ITU_HDR_EXC, addr_r[29:2]}
               : (kind_r == ITU_K_INDIR && !short)           ? {`ITU_HDR_ADDR, addr_r[29:2]}
               : {`ITU_HDR_ATOM, 27'h0, kind_r != ITU_K_NTAKEN};

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            seq_r       <= ITU_SEQ0;
            ovf_r       <= 1'b0;
            ovf_seen_r  <= 1'b0;
            trig_done_r <= 1'b0;
            sshot_r     <= 1'b0;
            trig        <= 1'b0;
            last_r      <= '0;
        end else begin
            seq_r       <= ctrl_wr ? ITU_SEQ0 : (en_r ? seq_nxt : seq_r);
            // Dropped packet blocks trace until the FIFO is empty again
            ovf_r       <= lost | (ovf_r & ~ovf_out);
            ovf_seen_r  <= lost | (ovf_seen_r & ~ctrl_wr);
            // Self-gated so the trigger stands for one cycle only
            trig        <= en_r & ~trig_done_r & ~trig & pair[ev[`ITU_EVT_TRIG]];
            trig_done_r <= trig | (trig_done_r & ~ctrl_wr);
            sshot_r     <= (sshot_r & ~ctrl_wr) |
                           (en_r & ev_r & res[`ITU_RES_ACMP+ev[`ITU_EVT_SSHOT]]);
            if (emit && fifo_rdy && kind_r != ITU_K_NTAKEN && kind_r != ITU_K_TAKEN)
                last_r <= addr_r;
        end
    end

    itu_fifo #(.W(`ITU_DATA_W), .DEPTH(`ITU_FIFO_DEPTH)) u_fifo (
        .clk       (clk),
        .rst       (rst),
        .in_valid  (push),
        .in_ready  (fifo_rdy),
        .in_data   (pkt),
        .out_valid (out_valid),
        .out_ready (out_ready),
        .out_data  (out_data)
    );
    assign fifo_empty = ~out_valid;
    assign status = {22'h0, seq_r, trig_done_r, sshot_r, ovf_r, ovf_seen_r, 1'b0, en_r};
endmodule

// Warm reset is deliberately not a port: only the cold reset reaches here
module itu_trace_unit import itu_pkg::*; (
    input  wire logic                                     clk,
    input  wire logic                                     rst,
    itu_link_if.dev                                       lnk,
    input  wire logic [`ITU_THREADS-1:0]                  elem_valid,
    input  wire logic [`ITU_THREADS-1:0][1:0]             elem_kind,
    input  wire logic [`ITU_THREADS-1:0][`ITU_ADDR_W-1:0] elem_addr,
    input  wire logic [`ITU_THREADS-1:0][31:0]            ctx_id,
    input  wire logic [`ITU_THREADS-1:0][31:0]            vm_ident,
    input  wire logic [`ITU_NUM_XTRIG-1:0]                xtrig,
    input  wire logic [`ITU_THREADS-1:0][`ITU_NUM_PERF-1:0] perf_evt_thr,
    input  wire logic [`ITU_NUM_PERF-1:0]                 perf_evt_shared
);
    logic [`ITU_THREADS-1:0]                  f_v, f_rdy, t_trig;
    logic [`ITU_THREADS-1:0][`ITU_DATA_W-1:0] f_d;
    logic [`ITU_THREADS-1:0][31:0]            stat;
    logic                                     v_r, last_r, trig_r, rv_r;
    logic [`ITU_DATA_W-1:0]                   d_r;
    logic [6:0]                               id_r;
    logic [31:0]                              rd_r;
    genvar t;
    generate
        for (t = 0; t < `ITU_THREADS; t++) begin : g_thr
            itu_thread_unit u_thr (
                .clk        (clk),
                .rst        (rst),
                .cfg_we     (lnk.cfg_wr & (lnk.cfg_thread == t)),
                .cfg_idx    (lnk.cfg_idx),
                .cfg_wdata  (lnk.cfg_wdata),
                .elem_valid (elem_valid[t]),
                .elem_kind  (elem_kind[t]),
                .elem_addr  (elem_addr[t]),
                .ctx_id     (ctx_id[t]),
                .vm_ident   (vm_ident[t]),
                .xtrig      (xtrig),
                .perf_evt   (perf_evt_thr[t] | perf_evt_shared),
                .out_valid  (f_v[t]),
                .out_ready  (f_rdy[t]),
                .out_data   (f_d[t]),
                .trig       (t_trig[t]),
                .status     (stat[t])
            );
        end
    endgenerate

    // Round-robin funnel: the thread not served last wins a tie
    wire load = ~v_r | lnk.atready;
    wire sel  = f_v[1] & (~f_v[0] | ~last_r);
    assign f_rdy = load ? (sel ? 2'b10 : 2'b01) : 2'b00;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            v_r    <= 1'b0;
            d_r    <= '0;
            id_r   <= 7'h00;
            last_r <= 1'b0;
            trig_r <= 1'b0;
            rv_r   <= 1'b0;
            rd_r   <= 32'h0000_0000;
        end else begin
            if (load) begin
                v_r <= |f_v;
                if (|f_v) begin
                    d_r    <= f_d[sel];
                    id_r   <= `ITU_ATID_BASE + 7'(sel);
                    last_r <= sel;
                end
            end
            trig_r <= |t_trig;
            rv_r   <= lnk.cfg_rd;
            if (lnk.cfg_rd) rd_r <= stat[lnk.cfg_thread];
        end
    end
    assign lnk.atvalid    = v_r;
    assign lnk.atdata     = d_r;
    assign lnk.atid       = id_r;
    assign lnk.trig       = trig_r;
    assign lnk.cfg_rvalid = rv_r;
    assign lnk.cfg_rdata  = rd_r;
endmodule

// ---- inc/itu_cfg.svh ----
// Configuration word indices, field positions, packet codes and sizes
`ifndef ITU_CFG_SVH
`define ITU_CFG_SVH
`define ITU_THREADS     2
`define ITU_NUM_RSP     8
`define ITU_NUM_CNT     2
`define ITU_NUM_EXTSEL  4
`define ITU_NUM_ACMP    4
`define ITU_NUM_XTRIG   4
`define ITU_NUM_PERF    28
`define ITU_FIFO_DEPTH  32
`define ITU_DATA_W      32
`define ITU_ADDR_W      32
`define ITU_IDX_W       5
`define ITU_CFG_WORDS   19
`define ITU_IDX_CTRL    5'h00
`define ITU_IDX_ACMP    5'h01
`define ITU_IDX_VM      5'h09
`define ITU_IDX_CTX     5'h0a
`define ITU_IDX_EXTSEL  5'h0b
`define ITU_IDX_RSEL    5'h0c
`define ITU_IDX_CNT     5'h0f
`define ITU_IDX_SEQ     5'h11
`define ITU_IDX_EVT     5'h12
`define ITU_CTRL_EN     0
`define ITU_RSEL_W      5
`define ITU_RSP_PER_WD  3
`define ITU_EXTSEL_STEP 8
`define ITU_CNT_RELOAD  15:0
`define ITU_CNT_EVT     18:16
`define ITU_SEQ_BACK    9
`define ITU_EVT_VIEW    2:0
`define ITU_EVT_TRIG    5:3
`define ITU_EVT_SSHOT   7:6
`define ITU_RES_ACMP    0
`define ITU_RES_VM      4
`define ITU_RES_CTX     5
`define ITU_RES_EXT     6
`define ITU_RES_CNT     10
`define ITU_RES_SEQ     12
`define ITU_RES_SSHOT   16
`define ITU_RES_N       32
`define ITU_HDR_ATOM    4'h1
`define ITU_HDR_ADDR    4'h2
`define ITU_HDR_EXC     4'h3
`define ITU_HDR_OVF     4'h4
`define ITU_ATID_BASE   7'h10
`endif

// ---- inc/itu_pkg.sv ----
// Types shared by the trace unit and its capture sink
package itu_pkg;
    typedef enum logic [1:0] {
        ITU_K_NTAKEN = 2'h0,
        ITU_K_TAKEN  = 2'h1,
        ITU_K_INDIR  = 2'h2,
        ITU_K_EXC    = 2'h3
    } itu_kind_t;
    typedef enum logic [3:0] {
        ITU_SEQ0 = 4'h1,
        ITU_SEQ1 = 4'h2,
        ITU_SEQ2 = 4'h4,
        ITU_SEQ3 = 4'h8
    } itu_seq_t;
endpackage

// ---- inc/itu_link_if.sv ----
// Programming port and trace stream between trace unit and capture sink
`timescale 1ns/1ps
`include "itu_cfg.svh"
interface itu_link_if (input wire logic clk, input wire logic rst);
    logic                    cfg_wr;
    logic                    cfg_rd;
    logic                    cfg_thread;
    logic [`ITU_IDX_W-1:0]   cfg_idx;
    logic [31:0]             cfg_wdata;
    logic [31:0]             cfg_rdata;
    logic                    cfg_rvalid;
    logic                    atvalid;
    logic                    atready;
    logic [`ITU_DATA_W-1:0]  atdata;
    logic [6:0]              atid;
    logic                    trig;
    modport dev  (input cfg_wr, cfg_rd, cfg_thread, cfg_idx, cfg_wdata, atready,
                  output cfg_rdata, cfg_rvalid, atvalid, atdata, atid, trig);
    modport sink (output cfg_wr, cfg_rd, cfg_thread, cfg_idx, cfg_wdata, atready,
                  input cfg_rdata, cfg_rvalid, atvalid, atdata, atid, trig);
endinterface

// ---- rtl/itu_trace_sink.sv ----
// Programming agent and trace capture sink at the far end of the link
`timescale 1ns/1ps
`include "itu_cfg.svh"
module itu_trace_sink import itu_pkg::*; (
    input  wire logic                  clk,
    input  wire logic                  rst,
    itu_link_if.sink                   lnk,
    input  wire logic                  user_wr,
    input  wire logic                  user_rd,
    input  wire logic                  user_thread,
    input  wire logic [`ITU_IDX_W-1:0] user_idx,
    input  wire logic [31:0]           user_wdata,
    output logic                       user_rvalid,
    output logic [31:0]                user_rdata,
    input  wire logic                  resume,
    input  wire logic                  cap_ready,
    output logic                       cap_valid,
    output logic [`ITU_DATA_W-1:0]     cap_data,
    output logic [6:0]                 cap_id,
    output logic                       stopped
);
    logic                  wr_r, rd_r, thr_r, rdy_r, rv_r, cv_r, stop_r;
    logic [`ITU_IDX_W-1:0] idx_r;
    logic [31:0]           wd_r, rdat_r;
    logic [`ITU_DATA_W-1:0] cd_r;
    logic [6:0]            cid_r;
    wire                   take = lnk.atvalid & rdy_r;
    // Configuration words only stage; the control write commits them,
    // so the user writes the control word last
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wr_r   <= 1'b0;
            rd_r   <= 1'b0;
            thr_r  <= 1'b0;
            idx_r  <= '0;
            wd_r   <= 32'h0000_0000;
            rv_r   <= 1'b0;
            rdat_r <= 32'h0000_0000;
            rdy_r  <= 1'b0;
            cv_r   <= 1'b0;
            cd_r   <= '0;
            cid_r  <= 7'h00;
            stop_r <= 1'b0;
        end else begin
            wr_r   <= user_wr;
            rd_r   <= user_rd;
            thr_r  <= user_thread;
            idx_r  <= user_idx;
            wd_r   <= user_wdata;
            rv_r   <= lnk.cfg_rvalid;
            if (lnk.cfg_rvalid) rdat_r <= lnk.cfg_rdata;
            // Trigger wins over a resume in the same cycle
            stop_r <= lnk.trig | (stop_r & ~resume);
            rdy_r  <= cap_ready & ~lnk.trig & (~stop_r | resume);
            cv_r   <= take;
            if (take) begin
                cd_r  <= lnk.atdata;
                cid_r <= lnk.atid;
            end
        end
    end
    assign lnk.cfg_wr     = wr_r;
    assign lnk.cfg_rd     = rd_r;
    assign lnk.cfg_thread = thr_r;
    assign lnk.cfg_idx    = idx_r;
    assign lnk.cfg_wdata  = wd_r;
    assign lnk.atready    = rdy_r;
    assign user_rvalid    = rv_r;
    assign user_rdata     = rdat_r;
    assign cap_valid      = cv_r;
    assign cap_data       = cd_r;
    assign cap_id         = cid_r;
    assign stopped        = stop_r;
endmodule

// ---- verif/itu_monitor.sv ----
// Checker on the link between trace unit and capture sink
`timescale 1ns/1ps
`include "itu_cfg.svh"
module itu_monitor (
    input wire logic                   clk,
    input wire logic                   rst,
    input wire logic                   cfg_wr,
    input wire logic                   cfg_rd,
    input wire logic                   cfg_thread,
    input wire logic [`ITU_IDX_W-1:0]  cfg_idx,
    input wire logic [31:0]            cfg_wdata,
    input wire logic [31:0]            cfg_rdata,
    input wire logic                   cfg_rvalid,
    input wire logic                   atvalid,
    input wire logic                   atready,
    input wire logic [`ITU_DATA_W-1:0] atdata,
    input wire logic [6:0]             atid,
    input wire logic                   trig
);
    logic en_seen_r;
    // Any enabling commit since reset; trace before it is forbidden
    always_ff @(posedge clk or posedge rst) begin
        if (rst)
            en_seen_r <= 1'b0;
        else if (cfg_wr && cfg_idx == `ITU_IDX_CTRL && cfg_wdata[0])
            en_seen_r <= 1'b1;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    AST_RD_ANSWER: assert property (cfg_rd |=> cfg_rvalid)
        else $error("read answer missing");
    AST_RD_CAUSE: assert property (cfg_rvalid |-> $past(cfg_rd))
        else $error("read answer without request");
    AST_RDATA_HOLD: assert property (!cfg_rvalid |-> $stable(cfg_rdata))
        else $error("read data moved without answer");
    AST_AT_HOLD: assert property (atvalid && !atready |=> atvalid && $stable({atid, atdata}))
        else $error("stream beat dropped or changed under stall");
    AST_ATID: assert property (atvalid |-> atid == 7'h10 || atid == 7'h11)
        else $error("stream id outside thread set");
    AST_HDR: assert property (atvalid |-> atdata[31:28] inside {4'h1, 4'h2, 4'h3, 4'h4})
        else $error("unknown packet header");
    AST_NO_EARLY: assert property (atvalid |-> en_seen_r)
        else $error("trace before enable");
    AST_TRIG_STOP: assert property (trig |=> !trig && !atready)
        else $error("trigger did not stop capture");
    COV_READ: cover property (cfg_rvalid);
    COV_BEAT: cover property (atvalid && atready);
    COV_STALL: cover property (atvalid && !atready);
    COV_TRIG: cover property (trig);
endmodule

// ---- verif/testbench.sv ----
// Self-checking bench joining the trace unit and the capture sink
`timescale 1ns/1ps
`include "itu_cfg.svh"
module testbench;
    logic             clk = 1'b0;
    logic             rst = 1'b1;
    logic [1:0]       ev = '0;
    logic [1:0][1:0]  ek = '0;
    logic [1:0][31:0] ea = '0;
    logic [1:0][27:0] pt = '0;
    logic [27:0]      ps = '0;
    logic             uwr = 1'b0;
    logic             urd = 1'b0;
    logic             uth = 1'b0;
    logic [4:0]       uidx = '0;
    logic [31:0]      uwd = '0;
    logic             resume = 1'b0;
    logic             cr = 1'b1;
    logic             urv, cv, stp;
    logic [31:0]      urdat, cd, s;
    logic [6:0]       cid;
    logic [38:0]      beats[$];
    int               mismatches = 0;
    int               total_checks = 0;
    int               n, k;
    always #10 clk = ~clk;
    itu_link_if lnk (.clk(clk), .rst(rst));
    itu_trace_unit itu_trace_unit_i (.clk(clk), .rst(rst), .lnk(lnk), .elem_valid(ev),
        .elem_kind(ek), .elem_addr(ea), .ctx_id('0), .vm_ident('0), .xtrig(4'h0),
        .perf_evt_thr(pt), .perf_evt_shared(ps));
    itu_trace_sink itu_trace_sink_i (.clk(clk), .rst(rst), .lnk(lnk), .user_wr(uwr),
        .user_rd(urd), .user_thread(uth), .user_idx(uidx), .user_wdata(uwd),
        .user_rvalid(urv), .user_rdata(urdat), .resume(resume), .cap_ready(cr),
        .cap_valid(cv), .cap_data(cd), .cap_id(cid), .stopped(stp));
    itu_monitor itu_monitor_i (.clk(clk), .rst(rst), .cfg_wr(lnk.cfg_wr), .cfg_rd(lnk.cfg_rd),
        .cfg_thread(lnk.cfg_thread), .cfg_idx(lnk.cfg_idx), .cfg_wdata(lnk.cfg_wdata),
        .cfg_rdata(lnk.cfg_rdata), .cfg_rvalid(lnk.cfg_rvalid), .atvalid(lnk.atvalid),
        .atready(lnk.atready), .atdata(lnk.atdata), .atid(lnk.atid), .trig(lnk.trig));
    always @(negedge clk) if (cv === 1'b1) beats.push_back({cid, cd});
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wr(input logic t, input logic [4:0] i, input logic [31:0] d);
        @(negedge clk);
        uwr = 1'b1;
        uth = t;
        uidx = i;
        uwd = d;
        @(negedge clk);
        uwr = 1'b0;
    endtask
    task automatic rd(input logic t, output logic [31:0] d);
        int j;
        @(negedge clk);
        urd = 1'b1;
        uth = t;
        @(negedge clk);
        urd = 1'b0;
        for (j = 0; j < 10 && urv !== 1'b1; j++) @(posedge clk) #1;
        chk("user_rvalid", {31'h0, urv}, 32'h1);
        if (urv !== 1'b1) tally_and_finish();
        d = urdat;
    endtask
    task automatic send(input logic t, input logic [1:0] kd, input logic [31:0] a, input int c);
        repeat (c) begin
            @(negedge clk);
            ev[t] = 1'b1;
            ek[t] = kd;
            ea[t] = a;
        end
        @(negedge clk);
        ev[t] = 1'b0;
    endtask
    task automatic take(input logic [6:0] id, input logic [31:0] d);
        logic [38:0] b;
        for (k = 0; k < 60 && beats.size() == 0; k++) @(posedge clk);
        if (beats.size() == 0) begin
            mismatches++;
            $display("[ERR] beat expected %h seen none", d);
            tally_and_finish();
        end
        b = beats.pop_front();
        chk("cap_id", {25'h0, b[38:32]}, {25'h0, id});
        chk("cap_data", b[31:0], d);
    endtask
    task automatic idle();
        repeat (12) @(posedge clk);
        chk("beat count", 32'(beats.size()), 32'h0);
    endtask
    task automatic prog(input logic t, input logic [31:0] r, input logic [31:0] e);
        wr(t, `ITU_IDX_RSEL, r);
        wr(t, `ITU_IDX_EVT, e);
        // Sequencer steps only on pair 1, kept dead, so it rests in state 0
        wr(t, `ITU_IDX_SEQ, 32'h9249);
        wr(t, `ITU_IDX_CTRL, 32'h1);
    endtask
    initial begin
        repeat (2) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        rd(1'b0, s);
        chk("status", s & 32'h3fd, 32'h40);
        send(1'b0, 2'h1, 32'h100, 1);
        idle();
        $display("test reset done");
        // Pair 0 sees sequencer state 0 (always true here), pairs 1 and 2 a dead resource
        prog(1'b0, 32'h3ffffd8c, 32'h08);
        rd(1'b0, s);
        chk("status", s & 32'h3fd, 32'h41);
        rd(1'b1, s);
        chk("status", s & 32'h3fd, 32'h40);
        send(1'b0, 2'h0, 32'h104, 1);
        send(1'b0, 2'h1, 32'h108, 1);
        send(1'b0, 2'h2, 32'h1000, 1);
        send(1'b0, 2'h3, 32'h2000, 1);
        take(7'h10, 32'h10000000);
        take(7'h10, 32'h10000001);
        take(7'h10, 32'h20000400);
        take(7'h10, 32'h30000800);
        send(1'b1, 2'h1, 32'h200, 1);
        idle();
        prog(1'b1, 32'h3ffffd8c, 32'h08);
        send(1'b1, 2'h1, 32'h204, 1);
        take(7'h11, 32'h10000001);
        $display("test flow done");
        wr(1'b0, `ITU_IDX_CTRL, 32'h0);
        wr(1'b1, `ITU_IDX_CTRL, 32'h0);
        rd(1'b0, s);
        chk("status", s & 32'h3fd, 32'h40);
        send(1'b0, 2'h1, 32'h300, 1);
        idle();
        $display("test disable done");
        // Selector 0 picks monitor event 0; pair 0 then follows that selector
        wr(1'b0, `ITU_IDX_EXTSEL, 32'h4);
        prog(1'b0, 32'h3ffffcc6, 32'h08);
        @(negedge clk);
        pt[1][0] = 1'b1;
        send(1'b0, 2'h1, 32'h400, 1);
        idle();
        ps[0] <= 1'b1;
        send(1'b0, 2'h1, 32'h404, 1);
        take(7'h10, 32'h10000001);
        wr(1'b0, `ITU_IDX_CTRL, 32'h0);
        pt = '0;
        ps = '0;
        $display("test events done");
        // Trigger on the true pair stops the sink, so the stalled stream overflows the FIFO
        prog(1'b0, 32'h3ffffd8c, 32'h00);
        for (k = 0; k < 20 && stp !== 1'b1; k++) @(posedge clk) #1;
        chk("stopped", {31'h0, stp}, 32'h1);
        if (stp !== 1'b1) tally_and_finish();
        send(1'b0, 2'h0, 32'h500, 40);
        rd(1'b0, s);
        chk("status", s & 32'h24, 32'h24);
        @(negedge clk);
        resume = 1'b1;
        @(negedge clk);
        resume = 1'b0;
        repeat (200) @(posedge clk);
        chk("drained", 32'(beats.size() > 0 && beats.size() <= 36), 32'h1);
        chk("last hdr", {28'h0, beats[$][31:28]}, 32'h4);
        beats.delete();
        $display("test overflow done");
        // Stalled sink holds one word in the funnel and 32 in the FIFO: none lost
        prog(1'b0, 32'h3ffffd8c, 32'h08);
        cr = 1'b0;
        for (n = 0; n < 33; n++) send(1'b0, 2'h2, 32'h1000 + 32'(n * 4), 1);
        rd(1'b0, s);
        chk("fifo fill", s & 32'h0c, 32'h0);
        cr = 1'b1;
        for (n = 0; n < 33; n++) take(7'h10, 32'h20000400 + 32'(n));
        idle();
        $display("test fifo done");
        tally_and_finish();
    end
endmodule
